// ---- src/icr_pkg.sv ----
// constants for the interrupt control register block
package icr_pkg;
   // apb byte offsets
   localparam logic [7:0] ICR_OFF_MAIN = 8'h00;
   localparam logic [7:0] ICR_OFF_EDGE = 8'h04;
   localparam logic [7:0] ICR_OFF_EXT = 8'h08;
   localparam logic [7:0] ICR_OFF_MODE = 8'h0c;
   localparam logic [7:0] ICR_OFF_IOC = 8'h10;
   localparam logic [7:0] ICR_OFF_PERF = 8'h14;
   localparam logic [7:0] ICR_OFF_PERE = 8'h18;
   localparam logic [7:0] ICR_OFF_PERP = 8'h1c;
   localparam logic [7:0] ICR_OFF_CORE = 8'h20;
   // main register fields
   localparam int ICR_B_GEN = 7;
   localparam int ICR_B_PEN = 6;
   localparam int ICR_B_T0E = 5;
   localparam int ICR_B_X0E = 4;
   localparam int ICR_B_PCE = 3;
   localparam int ICR_B_T0F = 2;
   localparam int ICR_B_X0F = 1;
   localparam int ICR_B_PCF = 0;
   // edge/priority register fields
   localparam int ICR_B_PUD = 7;
   localparam int ICR_B_EDG0 = 6;
   localparam int ICR_B_T0P = 2;
   localparam int ICR_B_X3P = 1;
   localparam int ICR_B_PCP = 0;
   // external register fields, then the mode register bit
   localparam int ICR_B_X2P = 7;
   localparam int ICR_B_X1P = 6;
   localparam int ICR_B_X1E = 3;
   localparam int ICR_B_X1F = 0;
   localparam int ICR_B_PRI = 7;
   // reset values
   localparam logic [7:0] ICR_RST_MAIN = 8'h00;
   localparam logic [7:0] ICR_RST_EDGE = 8'hff;
   localparam logic [7:0] ICR_RST_EXT = 8'hc0;
   localparam logic [7:0] ICR_RST_ZERO = 8'h00;
   // vectors, peripheral count and request states
   localparam logic [15:0] ICR_VEC_HIGH = 16'h0008;
   localparam logic [15:0] ICR_VEC_LOW = 16'h0018;
   localparam int ICR_NPER = 8;
   typedef enum logic [2:0] {
      ICR_IDLE = 3'b001,
      ICR_LOW = 3'b010,
      ICR_HIGH = 3'b100
   } icr_state_t;
endpackage

// ---- src/icr_top.sv ----
// interrupt control registers with apb slave and core request logic
//
// Overview of operation
// - flags set regardless of source and global enables; pin change needs its per-pin enable
// - compat mode: bit 7 gates all interrupts
// - priority mode: bit 7 gates high priority
// - compat mode: bit 6 gates peripheral sources
// - priority mode: bit 6 gates low priority
// - main register holds three source enables
// - timer overflow flag sticky until cleared
// - external zero flag set on edge
// - pin change flag on upper pins
// - mismatch keeps setting flag until port read
// - per-pin change enables reset disabled
// - bit 7 disables all port pull-ups
// - edge select bits: one rising, zero falling
// - timer, ext three, pin-change priority bits
// - ext two and one priority bits
// - ext three, two, one enables
// - ext three, two, one sticky flags
// - peripheral flags in separate bank
// - priority mode bit, reset to compatibility
// - request when flag, enable, global set
// - taking clears enable, return sets again
// - high preempts low, never reverse
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module icr_top #(
   parameter int NPER = icr_pkg::ICR_NPER
) (
   input wire logic mclk, // system clock
   input wire logic reset, // synchronous reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic timer_zero_ovf, // timer overflow pulse
   input wire logic [3:0] ext_irq_pins, // external pins 3..0
   input wire logic [3:0] port_b_pins, // upper port pins 7..4
   input wire logic [NPER-1:0] per_events, // peripheral event pulses
   input wire logic irq_ack, // core takes the request
   input wire logic return_from_interrupt, // core return pulse
   output logic irq_req, // request to core
   output logic [15:0] irq_vector, // vector address
   output logic port_pullup_disable // pull-ups off
);
   import icr_pkg::*;

   // ----------------------------------------
   // registers and sync
   // ----------------------------------------
   logic [7:0] main_q, edge_q, ext_q;
   logic priority_mode_enable_q;
   logic [3:0] per_pin_change_enables_q;
   logic [NPER-1:0] pflag_q, pen_q, pprio_q;
   logic [3:0] xs1_q, xs2_q, xs3_q, ps1_q, ps2_q, latch_q;
   logic rd_pend_q, rd_pend2_q;
   logic in_high_q, in_low_q;
   icr_state_t st_q;

   logic wr, rd;
   logic [3:0] xe, xen, xf, xp, xedge;
   logic pc_mis;
   logic hi_ok, lo_ok, compat_ok;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // external pin views: index 0..3
   assign xen = {ext_q[ICR_B_X1E+2], ext_q[ICR_B_X1E+1], ext_q[ICR_B_X1E],
                 main_q[ICR_B_X0E]};
   assign xf = {ext_q[ICR_B_X1F+2], ext_q[ICR_B_X1F+1], ext_q[ICR_B_X1F],
                main_q[ICR_B_X0F]};
   assign xp = {edge_q[ICR_B_X3P], ext_q[ICR_B_X2P], ext_q[ICR_B_X1P],
                1'b1}; // ext zero is always high priority
   assign xedge = {edge_q[ICR_B_EDG0-3], edge_q[ICR_B_EDG0-2],
                   edge_q[ICR_B_EDG0-1], edge_q[ICR_B_EDG0]};

   // two-stage sync, then a third stage for edges
   always_ff @(posedge mclk) begin
      if (reset) begin
         xs1_q <= 4'h0;
         xs2_q <= 4'h0;
         xs3_q <= 4'h0;
         ps1_q <= 4'h0;
         ps2_q <= 4'h0;
      end else begin
         xs1_q <= ext_irq_pins;
         xs2_q <= xs1_q;
         xs3_q <= xs2_q;
         ps1_q <= port_b_pins;
         ps2_q <= ps1_q;
      end
   end

   // edge detection per pin
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_edge
         assign xe[g] = xedge[g] ? (xs2_q[g] && !xs3_q[g])
                                 : (!xs2_q[g] && xs3_q[g]);
      end
   endgenerate

   // mismatch against port value latched by a read
   assign pc_mis = |((ps2_q ^ latch_q) & per_pin_change_enables_q);

   // port read latches pins one and again two cycles later
   always_ff @(posedge mclk) begin
      if (reset) begin
         latch_q <= 4'h0;
         rd_pend_q <= 1'b0;
         rd_pend2_q <= 1'b0;
      end else begin
         rd_pend_q <= rd && hit(paddr, ICR_OFF_IOC);
         rd_pend2_q <= rd_pend_q;
         if (rd_pend_q || rd_pend2_q)
            latch_q <= ps2_q;
      end
   end

   // ----------------------------------------
   // register writes and flags
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         main_q <= ICR_RST_MAIN;
         edge_q <= ICR_RST_EDGE;
         ext_q <= ICR_RST_EXT;
         priority_mode_enable_q <= 1'b0;
         per_pin_change_enables_q <= 4'h0;
         pen_q <= '0;
         pprio_q <= '0;
      end else begin
         if (wr && hit(paddr, ICR_OFF_MAIN))
            main_q <= pwdata[7:0];
         if (wr && hit(paddr, ICR_OFF_EDGE))
            edge_q <= pwdata[7:0];
         if (wr && hit(paddr, ICR_OFF_EXT))
            ext_q <= pwdata[7:0];
         if (wr && hit(paddr, ICR_OFF_MODE))
            priority_mode_enable_q <= pwdata[ICR_B_PRI];
         if (wr && hit(paddr, ICR_OFF_IOC))
            per_pin_change_enables_q <= pwdata[3:0];
         if (wr && hit(paddr, ICR_OFF_PERE))
            pen_q <= pwdata[NPER-1:0];
         if (wr && hit(paddr, ICR_OFF_PERP))
            pprio_q <= pwdata[NPER-1:0];
         // hardware set wins over software write, after the write
         if (timer_zero_ovf)
            main_q[ICR_B_T0F] <= 1'b1;
         if (xe[0])
            main_q[ICR_B_X0F] <= 1'b1;
         if (pc_mis)
            main_q[ICR_B_PCF] <= 1'b1;
         for (int i = 1; i < 4; i++)
            if (xe[i])
               ext_q[ICR_B_X1F+i-1] <= 1'b1;
         // taking an interrupt clears the admitting enable
         if (irq_ack && irq_req) begin
            if (!priority_mode_enable_q || st_q == ICR_HIGH)
               main_q[ICR_B_GEN] <= 1'b0;
            else
               main_q[ICR_B_PEN] <= 1'b0;
         end else if (return_from_interrupt) begin
            if (!priority_mode_enable_q || in_high_q)
               main_q[ICR_B_GEN] <= 1'b1;
            else
               main_q[ICR_B_PEN] <= 1'b1;
         end
      end
   end

   // peripheral flag bank, write one to clear
   always_ff @(posedge mclk) begin
      if (reset)
         pflag_q <= '0;
      else
         pflag_q <= (wr && hit(paddr, ICR_OFF_PERF) ?
                     pflag_q & ~pwdata[NPER-1:0] : pflag_q)
                    | per_events;
   end

   // ----------------------------------------
   // request logic
   // ----------------------------------------
   logic [NPER-1:0] pact;
   logic core_hi, core_lo, per_hi, per_lo, core_any, per_any;
   logic t0a, pca;
   logic [3:0] xa;
   assign t0a = main_q[ICR_B_T0F] && main_q[ICR_B_T0E];
   assign pca = main_q[ICR_B_PCF] && main_q[ICR_B_PCE];
   assign xa = xf & xen;
   assign pact = pflag_q & pen_q;
   assign core_hi = (t0a && edge_q[ICR_B_T0P]) || (pca && edge_q[ICR_B_PCP])
                    || |(xa & xp);
   assign core_lo = (t0a && !edge_q[ICR_B_T0P])
                    || (pca && !edge_q[ICR_B_PCP]) || |(xa & ~xp);
   assign per_hi = |(pact & pprio_q);
   assign per_lo = |(pact & ~pprio_q);
   assign core_any = t0a || pca || |xa;
   assign per_any = |pact;
   // compat: bit7 all, bit6 peripherals only
   assign compat_ok = main_q[ICR_B_GEN] &&
                      (core_any || (per_any && main_q[ICR_B_PEN]));
   assign hi_ok = main_q[ICR_B_GEN] && (core_hi || per_hi);
   assign lo_ok = main_q[ICR_B_GEN] && main_q[ICR_B_PEN]
                  && (core_lo || per_lo) && !in_high_q;

   // service nesting tracker
   always_ff @(posedge mclk) begin
      if (reset) begin
         in_high_q <= 1'b0;
         in_low_q <= 1'b0;
      end else if (irq_ack && irq_req) begin
         if (st_q == ICR_HIGH)
            in_high_q <= 1'b1;
         else
            in_low_q <= 1'b1;
      end else if (return_from_interrupt) begin
         if (in_high_q)
            in_high_q <= 1'b0;
         else
            in_low_q <= 1'b0;
      end
   end

   // request state, outputs registered
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= ICR_IDLE;
         irq_req <= 1'b0;
         irq_vector <= ICR_VEC_HIGH;
      end else begin
         case (st_q)
            ICR_IDLE, ICR_LOW, ICR_HIGH: begin
               if (!priority_mode_enable_q) begin
                  st_q <= compat_ok && !in_high_q ? ICR_HIGH : ICR_IDLE;
                  irq_req <= compat_ok && !in_high_q;
                  irq_vector <= ICR_VEC_HIGH;
               end else if (hi_ok && !in_high_q) begin
                  st_q <= ICR_HIGH;
                  irq_req <= 1'b1;
                  irq_vector <= ICR_VEC_HIGH;
               end else if (lo_ok && !in_low_q) begin
                  st_q <= ICR_LOW;
                  irq_req <= 1'b1;
                  irq_vector <= ICR_VEC_LOW;
               end else begin
                  st_q <= ICR_IDLE;
                  irq_req <= 1'b0;
               end
               if (irq_ack && irq_req) begin
                  st_q <= ICR_IDLE;
                  irq_req <= 1'b0;
               end
            end
            default: begin
               st_q <= ICR_IDLE;
               irq_req <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // apb read side
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         port_pullup_disable <= 1'b1;
      end else begin
         port_pullup_disable <= edge_q[ICR_B_PUD];
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               ICR_OFF_MAIN: prdata[7:0] <= main_q;
               ICR_OFF_EDGE: prdata[7:0] <= edge_q;
               ICR_OFF_EXT: prdata[7:0] <= ext_q;
               ICR_OFF_MODE: prdata[ICR_B_PRI] <= priority_mode_enable_q;
               ICR_OFF_IOC: prdata[7:0] <= {ps2_q, per_pin_change_enables_q};
               ICR_OFF_PERF: prdata[NPER-1:0] <= pflag_q;
               ICR_OFF_PERE: prdata[NPER-1:0] <= pen_q;
               ICR_OFF_PERP: prdata[NPER-1:0] <= pprio_q;
               ICR_OFF_CORE: prdata[3:0] <= {in_low_q, in_high_q, st_q == ICR_LOW,
                                         st_q == ICR_HIGH};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// ---- verif/icr_core_model.sv ----
// processor core model that takes requests and returns
`timescale 1ns/1ps
module icr_core_model #(parameter int LAT = 2) (
   input wire logic mclk, // clock
   input wire logic reset, // sync reset
   input wire logic irq_req, // request
   input wire logic [15:0] irq_vector, // vector
   input wire logic ret_go, // bench asks for return
   output logic irq_ack, // take pulse
   output logic return_from_interrupt, // return pulse
   output logic [15:0] vec_seen, // vector taken
   output logic [7:0] acks // count of takes
);
   int wait_q; // cycles request seen
   // take a standing request after LAT cycles, one pulse
   always_ff @(posedge mclk) begin
      irq_ack <= 1'b0;
      return_from_interrupt <= ret_go;
      if (reset) begin
         wait_q <= 0;
         acks <= 8'h00;
         vec_seen <= 16'h0000;
      end else if (irq_req && !irq_ack) begin
         wait_q <= wait_q + 1;
         if (wait_q == LAT) begin
            irq_ack <= 1'b1;
            vec_seen <= irq_vector;
            acks <= acks + 8'h01;
            wait_q <= 0;
         end
      end else wait_q <= 0;
   end
endmodule

// ---- verif/icr_monitor.sv ----
// port checker for the interrupt control registers
`timescale 1ns/1ps
module icr_monitor import icr_pkg::*; (
   input wire logic mclk, // clock
   input wire logic reset, // sync reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [7:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire logic irq_ack, // core ack
   input wire logic irq_req, // core request
   input wire logic [15:0] irq_vector, // vector
   input wire logic port_pullup_disable // pull-ups off
);
   logic prio_q; // mirror of priority mode
   logic wr_hit; // write taking effect
   assign wr_hit = psel && penable && pready && pwrite;
   // follow priority mode from committed writes
   always_ff @(posedge mclk) begin
      if (reset) prio_q <= 1'b0;
      else if (wr_hit && paddr == ICR_OFF_MODE) prio_q <= pwdata[ICR_B_PRI];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held");
   property p_cause; pready |-> $past(psel && !penable); endproperty
   a_cause: assert property (p_cause) else $error("ready no setup");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad error reply");
   property p_zero; !pready |-> prdata == 32'h0; endproperty
   a_zero: assert property (p_zero) else $error("stale read data");
   property p_pud;
      wr_hit && paddr == ICR_OFF_EDGE |=> ##1
         port_pullup_disable == $past(pwdata[ICR_B_PUD], 2);
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up copy wrong");
   // vector was chosen one edge earlier, under the mode of that edge
   property p_cvec;
      irq_req && !$past(prio_q) |-> irq_vector == ICR_VEC_HIGH;
   endproperty
   a_cvec: assert property (p_cvec) else $error("compat vector");
   property p_ack; irq_ack && irq_req |=> !irq_req; endproperty
   a_ack: assert property (p_ack) else $error("request after ack");
   property p_rel;
      $fell(reset) |-> irq_vector == ICR_VEC_HIGH && port_pullup_disable
         && !irq_req && !pready;
   endproperty
   a_rel: assert property (p_rel) else $error("reset state");
   c_ack: cover property (irq_ack && irq_req);
   c_low: cover property (irq_req && irq_vector == ICR_VEC_LOW);
   c_err: cover property (pslverr);
endmodule
bind icr_top icr_monitor u_mon (.mclk(mclk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
   .irq_req(irq_req), .irq_vector(irq_vector),
   .port_pullup_disable(port_pullup_disable));

// ---- verif/icr_tb_top.sv ----
// testbench for the interrupt control registers
`timescale 1ns/1ps
module icr_tb_top;
   import icr_pkg::*;
   logic mclk, reset, psel, penable, pwrite, t0, ack, ret, req, err;
   logic rdy, pud, ret_go, err_q;
   logic [7:0] paddr, per_ev, acks, n0;
   logic [31:0] pwdata, prdata, rd_q;
   logic [3:0] ext_p, port_p;
   logic [15:0] vec, vec_seen;
   int error_cnt = 0, checks = 0, tmo = 0;
   always #5 mclk = ~mclk;
   icr_top dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(rdy), .pslverr(err), .timer_zero_ovf(t0),
      .ext_irq_pins(ext_p), .port_b_pins(port_p), .per_events(per_ev),
      .irq_ack(ack), .return_from_interrupt(ret), .irq_req(req),
      .irq_vector(vec), .port_pullup_disable(pud));
   icr_core_model core (.mclk(mclk), .reset(reset), .irq_req(req),
      .irq_vector(vec), .ret_go(ret_go), .irq_ack(ack),
      .return_from_interrupt(ret), .vec_seen(vec_seen), .acks(acks));
   task finish_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // one apb transfer, held until ready; only the bench timeout ends a wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (rdy !== 1'b1);
      rd_q = prdata;
      err_q = err;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), {24'h0, e}, rd_q & {24'hffffff, m});
   endtask
   task pulse(input int k);
      @(posedge mclk);
      if (k == 0) t0 <= 1'b1; else if (k == 1) ret_go <= 1'b1;
      else per_ev <= 8'h01;
      @(posedge mclk);
      {t0, ret_go, per_ev} <= '0;
      cyc(2);
   endtask
   task take(input logic [15:0] v);
      while (acks === n0) @(posedge mclk);
      chk("acks", {24'h0, n0 + 8'h01}, {24'h0, acks});
      chk("vector", {16'h0, v}, {16'h0, vec_seen});
   endtask
   task t_reset;
      rd(ICR_OFF_MAIN, 8'hfe, 8'h00);
      rd(ICR_OFF_EDGE, 8'hff, 8'hff);
      rd(ICR_OFF_EXT, 8'hff, 8'hc0);
      rd(ICR_OFF_MODE, 8'hff, 8'h00);
      rd(ICR_OFF_IOC, 8'h0f, 8'h00);
      chk("pullup", 1, pud);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 1, err_q);
      wr(ICR_OFF_EXT, 8'hf8);
      rd(ICR_OFF_EXT, 8'hff, 8'hf8);
      wr(ICR_OFF_EDGE, 8'h7f);
      cyc(2);
      chk("pullup", 0, pud);
   endtask
   task t_ext;
      wr(ICR_OFF_MAIN, 8'h00);
      @(posedge mclk) ext_p <= 4'hf;
      cyc(5);
      rd(ICR_OFF_MAIN, 8'h02, 8'h02);
      rd(ICR_OFF_EXT, 8'h07, 8'h07);
      wr(ICR_OFF_MAIN, 8'h00);
      wr(ICR_OFF_EXT, 8'h00);
      cyc(3);
      rd(ICR_OFF_EXT, 8'h07, 8'h00);
      wr(ICR_OFF_EDGE, 8'h03);
      @(posedge mclk) ext_p <= 4'h0;
      cyc(5);
      rd(ICR_OFF_EXT, 8'h07, 8'h07);
      wr(ICR_OFF_EXT, 8'h00);
      @(posedge mclk) ext_p <= 4'hf;
      cyc(5);
      rd(ICR_OFF_EXT, 8'h07, 8'h00);
   endtask
   task t_pc;
      wr(ICR_OFF_IOC, 8'h0f);
      wr(ICR_OFF_MAIN, 8'h00);
      @(posedge mclk) port_p <= 4'h5;
      cyc(5);
      rd(ICR_OFF_MAIN, 8'h01, 8'h01);
      wr(ICR_OFF_MAIN, 8'h00);
      rd(ICR_OFF_MAIN, 8'h01, 8'h01);
      rd(ICR_OFF_IOC, 8'hf0, 8'h50);
      cyc(2);
      wr(ICR_OFF_MAIN, 8'h00);
      cyc(3);
      rd(ICR_OFF_MAIN, 8'h01, 8'h00);
   endtask
   task t_compat;
      wr(ICR_OFF_MAIN, 8'h00);
      pulse(0);
      rd(ICR_OFF_MAIN, 8'h04, 8'h04);
      wr(ICR_OFF_MAIN, 8'h24);
      cyc(4);
      chk("req", 0, req);
      n0 = acks;
      wr(ICR_OFF_MAIN, 8'ha4);
      take(ICR_VEC_HIGH);
      rd(ICR_OFF_MAIN, 8'h84, 8'h04);
      wr(ICR_OFF_MAIN, 8'h20);
      pulse(1);
      rd(ICR_OFF_MAIN, 8'hff, 8'ha0);
   endtask
   task t_prio;
      wr(ICR_OFF_MODE, 8'h80);
      wr(ICR_OFF_MAIN, 8'h00);
      wr(ICR_OFF_EDGE, 8'h07);
      pulse(0);
      n0 = acks;
      wr(ICR_OFF_MAIN, 8'ha4);
      take(ICR_VEC_HIGH);
      wr(ICR_OFF_EDGE, 8'h03);
      wr(ICR_OFF_MAIN, 8'h64);
      cyc(4);
      chk("req", 0, req);
      n0 = acks;
      pulse(1);
      take(ICR_VEC_LOW);
      rd(ICR_OFF_MAIN, 8'hc0, 8'h80);
      wr(ICR_OFF_MAIN, 8'h00);
      pulse(1);
      wr(ICR_OFF_MODE, 8'h00);
   endtask
   task t_per;
      wr(ICR_OFF_PERE, 8'h01);
      pulse(2);
      rd(ICR_OFF_PERF, 8'h01, 8'h01);
      wr(ICR_OFF_MAIN, 8'h80);
      cyc(4);
      chk("req", 0, req);
      n0 = acks;
      wr(ICR_OFF_MAIN, 8'hc0);
      take(ICR_VEC_HIGH);
      wr(ICR_OFF_PERF, 8'h01);
      rd(ICR_OFF_PERF, 8'h01, 8'h00);
   endtask
   // cut a hung run short
   always @(posedge mclk) begin
      tmo = tmo + 1;
      if (tmo == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      {mclk, psel, penable, pwrite, t0, ret_go} = '0;
      reset = 1'b1;
      {paddr, per_ev, ext_p, port_p, pwdata} = '0;
      cyc(4);
      reset <= 1'b0;
      t_reset();
      t_ext();
      t_pc();
      t_compat();
      t_prio();
      t_per();
      finish_test();
   end
endmodule
